// ===== bench/cps_link_monitor.sv
// cps_link_monitor: assertions on the link between device and controller.
// assumes one device on the line and a pull-up resolved by the bench.
`timescale 1ns/1ns
module cps_link_monitor #(
  parameter int PG_HOLD = 100
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic power_good_line,
  input wire logic pg_pull_oe,
  input wire logic sync_in,
  input wire logic sync_out,
  input wire logic sync_oe
);
  int lo_cnt_r;
  // reset counts as a long stretch of enable low, so no hold window follows it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) lo_cnt_r <= PG_HOLD + 16;
    else if (enable) lo_cnt_r <= 0;
    else if (lo_cnt_r < PG_HOLD + 16) lo_cnt_r <= lo_cnt_r + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_pull_gives_low: assert property (pg_pull_oe |-> !power_good_line)
    else $error("line high while pulled");
  a_enable_pulls_low: assert property ($rose(enable) |-> ##[1:5] pg_pull_oe)
    else $error("no pull after enable");
  a_hold_after_off: assert property ($fell(enable) |-> ##5 pg_pull_oe [*8])
    else $error("no hold after enable fell");
  a_hold_full_length: assert property (lo_cnt_r > 5 && lo_cnt_r < PG_HOLD - 4 |-> pg_pull_oe)
    else $error("hold ended early");
  a_off_releases: assert property (lo_cnt_r >= PG_HOLD + 8 |-> !pg_pull_oe)
    else $error("disabled device pulls line");
  a_strap_held: assert property (enable [*8] |=> $stable(sync_oe))
    else $error("sync direction changed");
  a_osc_half_period: assert property (sync_oe && $changed(sync_out) |=> $stable(sync_out) [*8])
    else $error("sync clock too fast");
  a_osc_running: assert property (sync_oe |-> ##[1:470] $changed(sync_out))
    else $error("sync clock stopped");
  c_start: cover property ($rose(enable));
  c_release: cover property ($fell(pg_pull_oe));
  c_stop: cover property ($fell(enable));
  c_ext_release: cover property ($fell(pg_pull_oe) && !sync_oe);
endmodule

// ===== bench/tb.sv
// tb: device and controller joined by the link, stepped through start-up cases.
// assumes the controller follows turn_on with enable while input_ok is high.
`timescale 1ns/1ns
module tb;
  import cps_pkg::*;
  localparam int SST = 200;
  localparam int PGH = 100;
  localparam int WDG = 64;
  logic clk = 0, rst_b = 0, strap = 0, lockout = 0, vout = 0, bal = 0;
  logic turn_on = 0, input_ok = 1, ext_pull = 0, ext_clk = 0, ext_run = 1, sync_q = 0;
  logic pump_enable, soft_start_limit, full_power, latched_off;
  logic pump_clk_en, ext_clock_active, load_allowed, enable_state;
  int cyc_cnt = 0, edge_cnt = 0, pump_cnt = 0, t0 = 0, p0 = 0, e0 = 0;
  int error_cnt = 0;
  int checks_done = 0;
  int m_st = 0; // 0 off, 1 line held low, 2 run
  cps_link_if link ();
  assign link.power_good_line = !(link.pg_pull_oe || ext_pull);
  assign link.sync_in = link.sync_oe ? link.sync_out : (ext_clk && ext_run);
  always #4 clk = ~clk;
  // toggles only on falling clock edges, so the pin never moves at a sampling edge
  always #24 ext_clk = ~ext_clk;
  // reference count of sync rising edges taken from the pin, set against pump strobes counted from the design
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    sync_q <= link.sync_in;
    if (link.sync_in && !sync_q) edge_cnt <= edge_cnt + 1;
    if (pump_clk_en) pump_cnt <= pump_cnt + 1;
  end
  cps_device #(.SS_TIMEOUT(SST), .PG_HOLD(PGH), .WDOG(WDG)) cps_device_inst (.clk(clk),
    .rst_b(rst_b), .link(link.dev), .clock_source_strap(strap), .input_lockout(lockout),
    .vout_above_th(vout), .precharge_balanced(bal), .pump_enable(pump_enable),
    .pump_clk_en(pump_clk_en), .soft_start_limit(soft_start_limit),
    .full_power(full_power), .latched_off(latched_off),
    .ext_clock_active(ext_clock_active));
  cps_controller cps_controller_inst (.clk(clk), .rst_b(rst_b), .link(link.ctl),
    .turn_on(turn_on), .input_ok(input_ok), .load_allowed(load_allowed),
    .enable_state(enable_state));
  cps_link_monitor #(.PG_HOLD(PGH)) cps_link_monitor_inst (.clk(clk), .rst_b(rst_b),
    .enable(link.enable), .power_good_line(link.power_good_line),
    .pg_pull_oe(link.pg_pull_oe), .sync_in(link.sync_in), .sync_out(link.sync_out),
    .sync_oe(link.sync_oe));
  task automatic stop_test();
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  // the line is judged against the model, never against the pull itself
  task automatic chk_line();
    chk(link.power_good_line, (m_st != 1) && !ext_pull, "line level");
  endtask
  function automatic logic cur(input int w);
    case (w)
      0: return link.enable;
      1: return link.pg_pull_oe;
      3: return ext_clock_active;
      default: return latched_off;
    endcase
  endfunction
  task automatic wait_sig(input int w, input logic v, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (cur(w) !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(cur(w), v, "wait ran out");
    if (cur(w) !== v) stop_test();
  endtask
  // checks land on a falling edge; stimulus goes out on the next rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  initial begin
    void'($urandom(74970));
    repeat (8) @(posedge clk);
    rst_b <= 1;
    cyc(6);
    @(posedge clk);
    vout <= 1;
    turn_on <= 1;
    wait_sig(0, 1, 20);
    m_st = 1;
    chk(enable_state, 1, "enable state");
    cyc($urandom_range(8, 40));
    chk_line();
    chk(pump_enable, 0, "pump before balance");
    chk(load_allowed, 0, "load before release");
    @(posedge clk);
    bal <= 1;
    wait_sig(1, 0, 20);
    m_st = 2;
    cyc(4);
    chk(full_power, 1, "full power");
    chk(soft_start_limit, 0, "soft start left");
    chk(load_allowed, 1, "load after release");
    chk_line();
    @(posedge clk);
    ext_pull <= 1;
    cyc(8);
    chk(full_power, 0, "full power under pull");
    chk(soft_start_limit, 1, "soft start under pull");
    chk(load_allowed, 0, "load under pull");
    @(posedge clk);
    ext_pull <= 0;
    cyc(8);
    chk(full_power, 1, "full power back");
    @(posedge clk);
    strap <= 1;
    cyc(8);
    chk(link.sync_oe, 1, "strap ignored");
    @(posedge clk);
    lockout <= 1;
    input_ok <= 0;
    m_st = 1;
    cyc(8);
    chk_line();
    chk(pump_enable, 0, "pump in lockout");
    chk(load_allowed, 0, "load in lockout");
    @(posedge clk);
    lockout <= 0;
    input_ok <= 1;
    wait_sig(1, 0, 40);
    m_st = 2;
    cyc(4);
    @(posedge clk);
    turn_on <= 0;
    wait_sig(0, 0, 20);
    m_st = 1;
    t0 = cyc_cnt;
    cyc(20);
    chk_line();
    wait_sig(1, 0, PGH + 10);
    chk((cyc_cnt - t0) >= PGH && (cyc_cnt - t0) <= PGH + 6, 1, "hold length");
    m_st = 0;
    chk_line();
    chk(load_allowed, 0, "load while disabled");
    @(posedge clk);
    vout <= 0;
    turn_on <= 1;
    wait_sig(0, 1, 20);
    m_st = 1;
    t0 = cyc_cnt;
    wait_sig(2, 1, SST + 20);
    chk((cyc_cnt - t0) >= SST && (cyc_cnt - t0) <= SST + 8, 1, "timeout length");
    chk_line();
    @(posedge clk);
    vout <= 1;
    cyc(10);
    chk(latched_off, 1, "latch held");
    @(posedge clk);
    turn_on <= 0;
    wait_sig(2, 0, 20);
    wait_sig(1, 0, PGH + 30);
    m_st = 0;
    chk(latched_off, 0, "latch cleared");
    @(posedge clk);
    turn_on <= 1;
    wait_sig(1, 1, 20);
    wait_sig(1, 0, 40);
    m_st = 2;
    cyc(4);
    chk(full_power, 1, "restart after toggle");
    // a fresh power-up with the strap floating, held fixed from here on
    @(posedge clk);
    rst_b <= 0;
    m_st = 0;
    cyc(4);
    chk_line();
    @(posedge clk);
    rst_b <= 1;
    wait_sig(1, 1, 20);
    m_st = 1;
    wait_sig(1, 0, 40);
    m_st = 2;
    cyc(8);
    chk(link.sync_oe, 0, "sync not driven");
    chk(ext_clock_active, 1, "external clock used");
    chk(full_power, 1, "full power external");
    p0 = pump_cnt;
    e0 = edge_cnt;
    cyc(120);
    chk((2 * (pump_cnt - p0) - (edge_cnt - e0)) inside {[-2:2]}, 1, "pump rate");
    @(posedge clk);
    ext_run <= 0;
    wait_sig(3, 0, WDG + 20);
    chk(link.sync_oe, 0, "sync stays input");
    @(posedge clk);
    ext_run <= 1;
    wait_sig(3, 1, 30);
    stop_test();
  end
endmodule

// ===== design/cps_controller.sv
// cps_controller: external sequencing controller for one or more modules.
// assumes its enable output fans out to every paralleled module.
`timescale 1ns/1ns
module cps_controller
  import cps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  cps_link_if.ctl link,
  input wire logic turn_on,
  input wire logic input_ok,
  output logic load_allowed,
  output logic enable_state
);
  import cps_pkg::*;

  logic pg_s;
  cps_sync2 #(.W(1)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d(link.power_good_line),
    .q(pg_s)
  );

  typedef struct packed {
    logic en;
    logic load;
  } cps_ctl_state_type;
  cps_ctl_state_type c_r, c_nxt;

  always_comb begin
    c_nxt = c_r;
    // see R8, R18: one shared enable; dropping it clears a latch
    c_nxt.en = turn_on;
    // see R13, R17, R19: trust the line only when enabled and supplied
    c_nxt.load = c_r.en && turn_on && input_ok && pg_s;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign link.enable = c_r.en;
  assign load_allowed = c_r.load;
  assign enable_state = c_r.en;
endmodule

// ===== design/cps_device.sv
// cps_device: start-up sequencer of one charge pump converter module.
// assumes comparator levels arrive asynchronously and pins are resolved outside.
// Behaviour
// R1 - strap captured once before pump starts
// R2 - grounded strap: internal clock driven on sync
// R3 - enable is an active-high digital level
// R4 - input lockout gates operation continuously
// R5 - pre-charge runs until balanced
// R6 - soft-start ends at output threshold, release
// R7 - soft-start timeout latches device off
// R8 - latch cleared only by enable toggle
// R9 - power good is open-drain pull-down only
// R10 - external low keeps device in soft-start
// R11 - shared line; full power after all release
// R12 - fault pulls shared line low
// R13 - disabled device never pulls line low; here it holds the line low for PG_HOLD cycles after enable falls (R16)
// R14 - pre-biased output still held low
// R15 - release only after clean start-up
// R16 - hold low 60ms after enable falls
// R17 - controller ignores line under lockout
// R18 - paralleled enables share one signal
// R19 - no load before power good high
// R20 - straps fixed from power-up
// R21 - pump runs at half sync rate
// R22 - watchdog falls back to internal clock
// R23 - timeouts counted in cycles, as parameters
// R24 - comparator and line inputs synchronised
`timescale 1ns/1ns
module cps_device
  import cps_pkg::*;
#(
  parameter int SS_TIMEOUT = cps_pkg::SS_TIMEOUT_CYC,
  parameter int PG_HOLD = cps_pkg::PG_HOLD_CYC,
  parameter int WDOG = cps_pkg::WDOG_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  cps_link_if.dev link,
  input wire logic clock_source_strap,
  input wire logic input_lockout,
  input wire logic vout_above_th,
  input wire logic precharge_balanced,
  output logic pump_enable,
  output logic pump_clk_en,
  output logic soft_start_limit,
  output logic full_power,
  output logic latched_off,
  output logic ext_clock_active
);
  import cps_pkg::*;

  logic [4:0] s_q;
  logic en_s, lock_s, vout_s, bal_s, pg_s;
  logic strap_s;
  logic sync_s;

  // see R24
  cps_sync2 #(.W(7)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .d({clock_source_strap, link.sync_in, link.enable, input_lockout, vout_above_th,
        precharge_balanced, link.power_good_line}),
    .q({strap_s, sync_s, s_q})
  );
  assign {en_s, lock_s, vout_s, bal_s, pg_s} = s_q;

  typedef struct packed {
    cps_state_type st;
    logic [CNT_W-1:0] cnt;
    logic strap_done;
    logic strap_ext;
    logic [8:0] div;
    logic osc;
    logic sync_last;
    logic [11:0] wd;
    logic ext_ok;
    logic pump_ph;
    logic pump_en;
    logic pump_clk;
    logic ss;
    logic full;
    logic latched;
    logic pull;
    logic drive_sync;
    logic ext_act;
  } cps_dev_state_type;

  cps_dev_state_type s_r, s_nxt;
  logic edge_src, src_edge;

  always_comb begin
    s_nxt = s_r;
    s_nxt.pump_clk = 1'h0;
    // internal oscillator from divider
    if (s_r.div == 9'(OSC_DIV_HALF - 1)) begin
      s_nxt.div = '0;
      s_nxt.osc = ~s_r.osc;
    end else begin
      s_nxt.div = s_r.div + 9'h1;
    end
    // see R22: watchdog on external sync edges
    s_nxt.sync_last = sync_s;
    if (sync_s != s_r.sync_last) begin
      s_nxt.wd = '0;
      s_nxt.ext_ok = 1'h1;
    end else if (s_r.wd == 12'(WDOG - 1)) begin
      s_nxt.ext_ok = 1'h0;
    end else begin
      s_nxt.wd = s_r.wd + 12'h1;
    end
    edge_src = (s_r.strap_ext && s_r.ext_ok) ? (sync_s && !s_r.sync_last)
                                             : (s_nxt.osc && !s_r.osc);
    src_edge = edge_src;
    // see R21: pump strobe every second sync rising edge
    if (src_edge) begin
      s_nxt.pump_ph = ~s_r.pump_ph;
      s_nxt.pump_clk = s_r.pump_ph && s_r.pump_en;
    end
    // see R3, R4
    case (s_r.st)
      CPS_OFF: begin
        s_nxt.pull = 1'h0;  // see R13
        if (en_s && !lock_s) begin
          if (!s_r.strap_done) begin
            // see R1, R20: strap taken once, before the pump stage
            s_nxt.strap_done = 1'h1;
            s_nxt.strap_ext = (strap_s != STRAP_GROUNDED);
          end
          s_nxt.st = CPS_PRECHARGE;
          s_nxt.pull = 1'h1;  // see R14
        end
      end
      CPS_PRECHARGE: begin
        // see R5
        if (bal_s) begin
          s_nxt.st = CPS_SOFTSTART;
          s_nxt.cnt = '0;
          s_nxt.pump_en = 1'h1;
          s_nxt.ss = 1'h1;
        end
      end
      CPS_SOFTSTART: begin
        s_nxt.cnt = s_r.cnt + 1'h1;
        if (vout_s) begin
          // see R6, R9, R15: release at output threshold, before exit
          s_nxt.pull = 1'h0;
        end
        if (vout_s && pg_s) begin
          // see R10, R11
          s_nxt.st = CPS_RUN;
          s_nxt.ss = 1'h0;
          s_nxt.full = 1'h1;
        end else if (!vout_s && s_r.cnt >= CNT_W'(SS_TIMEOUT - 1)) begin
          // see R7, R23
          s_nxt.st = CPS_LATCHED;
          s_nxt.latched = 1'h1;
          s_nxt.pump_en = 1'h0;
          s_nxt.ss = 1'h0;
          s_nxt.pull = 1'h1;  // see R12
        end
      end
      CPS_RUN: begin
        if (!pg_s) begin
          // see R10: external pull-down drops back to soft-start
          s_nxt.st = CPS_SOFTSTART;
          s_nxt.cnt = '0;
          s_nxt.ss = 1'h1;
          s_nxt.full = 1'h0;
        end
        if (!vout_s) begin
          s_nxt.pull = 1'h1;  // see R12
          s_nxt.st = CPS_SOFTSTART;
          s_nxt.cnt = '0;
          s_nxt.ss = 1'h1;
          s_nxt.full = 1'h0;
        end
      end
      CPS_LATCHED: begin
        // see R8: leave only once enable has dropped
        if (!en_s) begin
          s_nxt.latched = 1'h0;
        end
      end
      default: begin
      end
    endcase
    // see R4: lockout stops switching at once
    if (lock_s && s_r.st != CPS_OFF && s_r.st != CPS_PGHOLD && s_r.st != CPS_LATCHED) begin
      s_nxt.st = CPS_PRECHARGE;
      s_nxt.pump_en = 1'h0;
      s_nxt.ss = 1'h0;
      s_nxt.full = 1'h0;
      s_nxt.pull = 1'h1;
    end
    // see R16: enable fall starts the hold
    if (!en_s && s_r.st != CPS_OFF && s_r.st != CPS_PGHOLD) begin
      s_nxt.st = CPS_PGHOLD;
      s_nxt.cnt = '0;
      s_nxt.pump_en = 1'h0;
      s_nxt.ss = 1'h0;
      s_nxt.full = 1'h0;
      s_nxt.latched = 1'h0;
      s_nxt.pull = 1'h1;
    end
    if (s_r.st == CPS_PGHOLD) begin
      s_nxt.cnt = s_r.cnt + 1'h1;
      if (s_r.cnt >= CNT_W'(PG_HOLD - 1)) begin
        s_nxt.st = CPS_OFF;
        s_nxt.pull = 1'h0;
      end
    end
    // registered copies, so sync direction and source flag leave straight from flops
    s_nxt.drive_sync = s_nxt.strap_done && !s_nxt.strap_ext;
    s_nxt.ext_act = s_nxt.strap_ext && s_nxt.ext_ok;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.pg_pull_oe = s_r.pull;
  // see R2: grounded strap drives the internal clock out
  assign link.sync_out = s_r.osc;
  assign link.sync_oe = s_r.drive_sync;
  assign pump_enable = s_r.pump_en;
  assign pump_clk_en = s_r.pump_clk;
  assign soft_start_limit = s_r.ss;
  assign full_power = s_r.full;
  assign latched_off = s_r.latched;
  assign ext_clock_active = s_r.ext_act;  // see R22
endmodule

// ===== design/cps_link_if.sv
// cps_link_if: wires between the converter module and its controller.
// assumes the bench resolves power_good_line from every open-drain pull.
`timescale 1ns/1ns
interface cps_link_if;
  logic enable;
  logic power_good_line;
  logic pg_pull_oe;
  logic sync_in;
  logic sync_out;
  logic sync_oe;
  modport dev (
    input enable,
    input power_good_line,
    output pg_pull_oe,
    input sync_in,
    output sync_out,
    output sync_oe
  );
  modport ctl (
    output enable,
    input power_good_line
  );
endinterface

// ===== design/cps_pkg.sv
// cps_pkg: shared constants and types for the charge pump start-up sequencer.
// assumes a single 125 MHz clock drives every module that imports it.
package cps_pkg;
  localparam int CLK_MHZ = 125;
  localparam int SS_TIMEOUT_MS = 100;
  localparam int PG_HOLD_MS = 60;
  localparam int SS_TIMEOUT_CYC = SS_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int PG_HOLD_CYC = PG_HOLD_MS * 1000 * CLK_MHZ;
  localparam int OSC_DIV_HALF = 231;
  localparam int WDOG_CYC = 2048;
  localparam int CNT_W = 24;
  localparam logic STRAP_GROUNDED = 1'h0;
  localparam logic RST_LOW = 1'h0;
  localparam logic [1:0] SYNC_RST = 2'h0;

  typedef enum logic [2:0] {
    CPS_OFF = 3'h0,
    CPS_PRECHARGE = 3'h1,
    CPS_SOFTSTART = 3'h2,
    CPS_RUN = 3'h3,
    CPS_LATCHED = 3'h4,
    CPS_PGHOLD = 3'h5
  } cps_state_type;
endpackage

// ===== design/cps_sync2.sv
// cps_sync2: generic two-flop synchroniser, one per bit.
// assumes inputs are asynchronous levels.
`timescale 1ns/1ns
module cps_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
